// >>> design/pmx_consts.svh
// constants for the port 0 output pin mux: codes, widths, timing
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// ----------------------------------------------------------------
// strap field layout and mode codes
// ----------------------------------------------------------------
`define PMX_STRAP_W 3
`define PMX_CODE_MII_MAC 3'h0
`define PMX_CODE_MII_PHY 3'h1
`define PMX_CODE_MII_200_12MA 3'h2
`define PMX_CODE_MII_200_16MA 3'h3
`define PMX_CODE_RMII_OUT_12MA 3'h4
`define PMX_CODE_RMII_OUT_16MA 3'h5
`define PMX_CODE_RMII_IN 3'h6
`define PMX_CODE_RSVD 3'h7

// ----------------------------------------------------------------
// data path shape
// ----------------------------------------------------------------
`define PMX_NIBBLE_W 4
`define PMX_FIFO_DEPTH 4
`define PMX_DATA_RST 4'h0

// ----------------------------------------------------------------
// timing: core clock and generated reference clock
// ----------------------------------------------------------------
`define PMX_CLK_PERIOD_NS 10
`define PMX_REF_PERIOD_NS 160
`define PMX_REF_HALF_CYC ((`PMX_REF_PERIOD_NS / 2) / `PMX_CLK_PERIOD_NS)
`define PMX_DIV_W 4

`endif

// >>> design/pmx_pkg.sv
// types shared by the port 0 output pin mux modules
package pmx_pkg;

   // ----------------------------------------------------------------
   // decoded port personality
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PMX_MII_MAC,
      PMX_MII_PHY,
      PMX_RMII_PHY,
      PMX_MODE_RSVD
   } pmx_mode_t;

   // ----------------------------------------------------------------
   // which half of a nibble goes out in rmii
   // ----------------------------------------------------------------
   typedef enum logic {
      PMX_PH_LOW,
      PMX_PH_HIGH
   } pmx_phase_t;

endpackage : pmx_pkg

// >>> design/pmx_strm_if.sv
// valid/ready nibble stream between the mux modules
`timescale 1ns/1ns
`include "pmx_consts.svh"

interface pmx_strm_if;
   logic [`PMX_NIBBLE_W-1:0] data; // payload nibble
   logic valid; // source holds data
   logic ready; // sink can take it

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : pmx_strm_if

// >>> design/pmx_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ns

module pmx_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // first stage, read only by the second
   logic [W-1:0] meta_r;

   // ----------------------------------------------------------------
   // no reset: straps must pass through while reset is held
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule : pmx_sync

// >>> design/pmx_fifo.sv
// small fifo carrying nibbles toward the output pins
`timescale 1ns/1ns
`include "pmx_consts.svh"

module pmx_fifo #(
   parameter int WIDTH = `PMX_NIBBLE_W,
   parameter int DEPTH = `PMX_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   pmx_strm_if.snk wr,
   pmx_strm_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // storage words
   logic [AW-1:0] wp_r; // write pointer
   logic [AW-1:0] rp_r; // read pointer
   logic [AW:0] cnt_r; // words held
   logic [AW:0] cnt_nxt;
   logic ready_r; // registered not-full
   logic push;
   logic pop;

   assign push = wr.valid && ready_r;
   assign pop = rd.valid && rd.ready;
   assign wr.ready = ready_r;
   assign rd.valid = (cnt_r != '0);
   assign rd.data = mem[rp_r];

   // ----------------------------------------------------------------
   // occupancy; ready is registered from the next count so it is never late
   // ----------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         ready_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ready_r <= (cnt_nxt < (AW+1)'(DEPTH));
      end
   end

   // ----------------------------------------------------------------
   // pointers wrap naturally, depth is a power of two
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   // storage has no reset, only written words are read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= wr.data;
      end
   end
endmodule : pmx_fifo

// >>> design/pmx_top.sv
// port 0 output pin mux: strap decode, clocking, data and valid pins
//
// Operation
// R1: mii mac drives transmit nibble bits
// R2: mii phy drives receive nibble bits
// R3: rmii leaves data bit 2 unused
// R4: rmii dibit on data bits 1:0
// R5: isolate tristates data and valid in phy
// R6: strap 000 mac, 001 phy, 111 reserved
// R7: 010/011 mii phy 200 mbps clock out
// R8: 100/101 rmii clock out, 110 in
// R9: straps read from data pins 2:0
// R10: mac valid pin is transmit enable
// R11: mii phy valid pin is rx valid
// R12: rmii valid pin is carrier/data valid
// R13: mii pins timed by reference clock
// R14: rmii one reference clock times port
// R15: straps latched in reset, drive after
`timescale 1ns/1ns
`include "pmx_consts.svh"

module pmx_top
   import pmx_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   // user nibble stream from the switch
   input wire logic [`PMX_NIBBLE_W-1:0] TX_DATA,
   input wire logic TX_VALID,
   output logic TX_READY,
   // isolate control from the emulated phy control
   input wire logic ISOLATE_OUTPUTS_BIT,
   // reference clock pin
   input wire logic PORT0_OUT_REF_CLOCK_I,
   output logic PORT0_OUT_REF_CLOCK_O,
   output logic PORT0_OUT_REF_CLOCK_OE,
   // data pins, low three double as straps
   input wire logic [`PMX_STRAP_W-1:0] PORT0_OUT_DATA_NIBBLE_I,
   output logic [`PMX_NIBBLE_W-1:0] PORT0_OUT_DATA_NIBBLE_O,
   output logic [`PMX_NIBBLE_W-1:0] PORT0_OUT_DATA_NIBBLE_OE,
   // data valid pin
   output logic PORT0_OUT_DATA_VALID_O,
   output logic PORT0_OUT_DATA_VALID_OE,
   // decoded configuration
   output logic [`PMX_STRAP_W-1:0] PORT0_CFG_STRAP_FIELD,
   output logic CFG_SPEED_200,
   output logic CFG_CLK_16MA,
   output logic CFG_CLK_OUT,
   output logic CFG_DONE
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pmx_strm_if up_if (); // user side of the fifo
   pmx_strm_if dn_if (); // pin side of the fifo

   logic [`PMX_STRAP_W:0] pin_sync; // synced straps and ref clock
   logic [`PMX_STRAP_W-1:0] strap_r; // strap value held from reset
   logic [`PMX_STRAP_W-1:0] strap_q_r; // strap copy with defined reset
   logic done_r; // configuration taken
   pmx_mode_t mode_r; // decoded mode
   logic clk_out_r; // device makes the ref clock
   logic ref_s; // synced ref clock input
   logic ref_d_r; // delayed synced ref clock
   logic [`PMX_DIV_W-1:0] div_r; // divider count
   logic ref_o_r; // generated ref clock level
   logic ref_oe_r; // ref clock driver enable
   logic tick; // rising reference edge
   logic run; // data path active
   logic isolated; // phy mode with isolate set
   pmx_phase_t phase_r; // rmii dibit phase
   logic [`PMX_NIBBLE_W-1:0] data_r; // data pin level
   logic [`PMX_NIBBLE_W-1:0] data_oe_r; // data pin enables
   logic dv_r; // valid pin level
   logic dv_oe_r; // valid pin enable
   logic pop; // take a nibble from the fifo

   localparam logic [`PMX_DIV_W-1:0] DIV_LAST =
      `PMX_DIV_W'(`PMX_REF_HALF_CYC - 1);

   // ----------------------------------------------------------------
   // strap decode
   // ----------------------------------------------------------------
   function automatic pmx_mode_t decode(input logic [`PMX_STRAP_W-1:0] c);
      pmx_mode_t m;
      m = PMX_MODE_RSVD;
      unique case (c)
         `PMX_CODE_MII_MAC: m = PMX_MII_MAC; // R6
         `PMX_CODE_MII_PHY: m = PMX_MII_PHY; // R6
         `PMX_CODE_MII_200_12MA,
         `PMX_CODE_MII_200_16MA: m = PMX_MII_PHY; // R7
         `PMX_CODE_RMII_OUT_12MA,
         `PMX_CODE_RMII_OUT_16MA,
         `PMX_CODE_RMII_IN: m = PMX_RMII_PHY; // R8
         `PMX_CODE_RSVD: m = PMX_MODE_RSVD; // R6
      endcase
      return m;
   endfunction : decode

   // ----------------------------------------------------------------
   // pin synchroniser: straps and the reference clock
   // ----------------------------------------------------------------
   pmx_sync #(
      .W(`PMX_STRAP_W + 1)
   ) u_sync (
      .clk(CLK),
      .d({PORT0_OUT_REF_CLOCK_I, PORT0_OUT_DATA_NIBBLE_I}),
      .q(pin_sync)
   );

   assign ref_s = pin_sync[`PMX_STRAP_W];

   // ----------------------------------------------------------------
   // strap capture: loads every edge while reset is held
   // ----------------------------------------------------------------
   // no async reset here so the pin value can be taken; reset must
   // last a few edges for the synchroniser to fill
   always_ff @(posedge CLK) begin
      if (RST) begin
         strap_r <= pin_sync[`PMX_STRAP_W-1:0]; // R9 R15
      end
   end

   // ----------------------------------------------------------------
   // configuration outputs, defined during reset
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         done_r <= 1'b0;
         strap_q_r <= `PMX_CODE_MII_MAC;
         mode_r <= PMX_MODE_RSVD;
         clk_out_r <= 1'b0;
         CFG_SPEED_200 <= 1'b0;
         CFG_CLK_16MA <= 1'b0;
      end else begin
         done_r <= 1'b1; // R15
         strap_q_r <= strap_r;
         mode_r <= decode(strap_r);
         // speed and strength only matter in clock-out modes
         CFG_SPEED_200 <= (strap_r == `PMX_CODE_MII_200_12MA) ||
                          (strap_r == `PMX_CODE_MII_200_16MA); // R7
         CFG_CLK_16MA <= (strap_r == `PMX_CODE_MII_200_16MA) ||
                         (strap_r == `PMX_CODE_RMII_OUT_16MA); // R7 R8
         // clock out in every phy code but the rmii input one
         clk_out_r <= (strap_r != `PMX_CODE_MII_MAC) &&
                      (strap_r != `PMX_CODE_RMII_IN) &&
                      (strap_r != `PMX_CODE_RSVD); // R8 R13
      end
   end

   assign PORT0_CFG_STRAP_FIELD = strap_q_r;
   assign CFG_CLK_OUT = clk_out_r;
   assign CFG_DONE = done_r;

   // done and mode are set together at the first edge after release
   assign run = done_r && (mode_r != PMX_MODE_RSVD);
   assign isolated = ISOLATE_OUTPUTS_BIT &&
                     ((mode_r == PMX_MII_PHY) ||
                      (mode_r == PMX_RMII_PHY)); // R5

   // ----------------------------------------------------------------
   // reference clock generator for clock-out modes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_r <= '0;
         ref_o_r <= 1'b0;
      end else if (!clk_out_r) begin
         div_r <= '0;
         ref_o_r <= 1'b0;
      end else if (div_r == DIV_LAST) begin
         div_r <= '0;
         ref_o_r <= !ref_o_r; // R13 R14
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // reference clock driver enable
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_oe_r <= 1'b0;
      end else begin
         ref_oe_r <= run && clk_out_r && !isolated; // R13
      end
   end

   assign PORT0_OUT_REF_CLOCK_O = ref_o_r;
   assign PORT0_OUT_REF_CLOCK_OE = ref_oe_r;

   // ----------------------------------------------------------------
   // edge finder for an incoming reference clock
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_d_r <= 1'b0;
      end else begin
         ref_d_r <= ref_s;
      end
   end

   // a 50 mhz input clock is above what a 100 mhz sampler can
   // follow; rmii input mode only works for slower bench clocks
   assign tick = clk_out_r ? (div_r == DIV_LAST) && !ref_o_r
                           : ref_s && !ref_d_r; // R13 R14

   // ----------------------------------------------------------------
   // nibble fifo in front of the pins
   // ----------------------------------------------------------------
   assign up_if.data = TX_DATA;
   assign up_if.valid = TX_VALID;
   assign TX_READY = up_if.ready;

   pmx_fifo #(
      .WIDTH(`PMX_NIBBLE_W),
      .DEPTH(`PMX_FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst(RST),
      .wr(up_if.snk),
      .rd(dn_if.src)
   );

   // mii takes a nibble per edge, rmii one per two edges
   assign pop = tick && run && dn_if.valid &&
                ((mode_r != PMX_RMII_PHY) || (phase_r == PMX_PH_HIGH));
   assign dn_if.ready = pop;

   // ----------------------------------------------------------------
   // pin levels: updated on each rising reference edge
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         data_r <= `PMX_DATA_RST;
         dv_r <= 1'b0;
         phase_r <= PMX_PH_LOW;
      end else if (!run) begin
         data_r <= `PMX_DATA_RST;
         dv_r <= 1'b0;
         phase_r <= PMX_PH_LOW;
      end else if (tick) begin
         unique case (mode_r)
            PMX_MII_MAC,
            PMX_MII_PHY: begin
               // tx nibble to phy or rx nibble to mac
               data_r <= dn_if.valid ? dn_if.data
                                     : `PMX_DATA_RST; // R1 R2
               dv_r <= dn_if.valid; // R10 R11
               phase_r <= PMX_PH_LOW;
            end
            PMX_RMII_PHY: begin
               // low dibit first, upper bits stay quiet
               if (phase_r == PMX_PH_LOW) begin
                  // idle dibit is driven 0, never a stale fifo word
                  data_r <= dn_if.valid ? {2'h0, dn_if.data[1:0]}
                                        : `PMX_DATA_RST; // R3 R4
                  dv_r <= dn_if.valid; // R12
                  if (dn_if.valid) begin
                     phase_r <= PMX_PH_HIGH;
                  end
               end else begin
                  data_r <= {2'h0, dn_if.data[3:2]}; // R3 R4
                  dv_r <= 1'b1; // R12
                  phase_r <= PMX_PH_LOW;
               end
            end
            PMX_MODE_RSVD: begin
               data_r <= `PMX_DATA_RST;
               dv_r <= 1'b0;
               phase_r <= PMX_PH_LOW;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin enables: nothing driven before release or when isolated
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         data_oe_r <= '0;
         dv_oe_r <= 1'b0;
      end else if (!run || isolated) begin
         data_oe_r <= '0; // R5 R15
         dv_oe_r <= 1'b0; // R5
      end else if (mode_r == PMX_RMII_PHY) begin
         data_oe_r <= 4'h3; // R3
         dv_oe_r <= 1'b1;
      end else begin
         data_oe_r <= 4'hf;
         dv_oe_r <= 1'b1;
      end
   end

   assign PORT0_OUT_DATA_NIBBLE_O = data_r;
   assign PORT0_OUT_DATA_NIBBLE_OE = data_oe_r;
   assign PORT0_OUT_DATA_VALID_O = dv_r;
   assign PORT0_OUT_DATA_VALID_OE = dv_oe_r;

endmodule : pmx_top

// >>> bench/pmx_props.sv
// concurrent checks on the port 0 output pin mux ports
`timescale 1ns/1ns
`include "pmx_consts.svh"

module pmx_props (
   input wire logic CLK,
   input wire logic RST,
   input wire logic TX_READY,
   input wire logic ISOLATE_OUTPUTS_BIT,
   input wire logic PORT0_OUT_REF_CLOCK_O,
   input wire logic PORT0_OUT_REF_CLOCK_OE,
   input wire logic [`PMX_STRAP_W-1:0] PORT0_OUT_DATA_NIBBLE_I,
   input wire logic [`PMX_NIBBLE_W-1:0] PORT0_OUT_DATA_NIBBLE_O,
   input wire logic [`PMX_NIBBLE_W-1:0] PORT0_OUT_DATA_NIBBLE_OE,
   input wire logic PORT0_OUT_DATA_VALID_O,
   input wire logic PORT0_OUT_DATA_VALID_OE,
   input wire logic [`PMX_STRAP_W-1:0] PORT0_CFG_STRAP_FIELD,
   input wire logic CFG_SPEED_200,
   input wire logic CFG_CLK_16MA,
   input wire logic CFG_CLK_OUT,
   input wire logic CFG_DONE
);
   logic [2:0] sf; // captured strap
   logic [3:0] oe; // data pin enables
   logic iso; // isolate request
   assign sf = PORT0_CFG_STRAP_FIELD;
   assign oe = PORT0_OUT_DATA_NIBBLE_OE;
   assign iso = ISOLATE_OUTPUTS_BIT;
   default clocking dcb @(posedge CLK); endclocking
   default disable iff (RST);
   // ----------------------------------------------------------------
   // named steps
   // ----------------------------------------------------------------
   sequence s_tick; // reference clock rises
      $rose(PORT0_OUT_REF_CLOCK_O);
   endsequence
   sequence s_high_half; // eight cycles high then low
      PORT0_OUT_REF_CLOCK_O [*8] ##1 !PORT0_OUT_REF_CLOCK_O;
   endsequence
   sequence s_settled; // enable flops have followed isolate
      CFG_DONE && $past(CFG_DONE) && !iso && !$past(iso) && !$past(iso, 2);
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_RST_QUIET: assert property ($fell(RST) |-> $past(oe) == 4'h0
      && !$past(PORT0_OUT_DATA_VALID_OE) && !$past(TX_READY))
      else $error("pins driven during reset");
   AST_DONE_RISE: assert property ($fell(RST) |=> CFG_DONE)
      else $error("configuration not done after release");
   AST_STRAP_PINS: assert property ($fell(RST) |=>
      sf == $past(PORT0_OUT_DATA_NIBBLE_I, 2))
      else $error("strap not taken from data pins");
   AST_STRAP_HOLD: assert property (CFG_DONE && $past(CFG_DONE) |->
      $stable(sf)) else $error("strap changed after reset");
   AST_DECODE: assert property (CFG_DONE |->
      CFG_SPEED_200 == (sf inside {3'h2, 3'h3})
      && CFG_CLK_16MA == (sf inside {3'h3, 3'h5}))
      else $error("speed or strength decode wrong");
   AST_CLK_DIR: assert property (CFG_DONE |->
      CFG_CLK_OUT == (sf inside {[3'h1:3'h5]}))
      else $error("clock direction decode wrong");
   AST_REF_OE: assert property (s_settled |->
      PORT0_OUT_REF_CLOCK_OE == CFG_CLK_OUT)
      else $error("reference clock enable wrong");
   AST_RMII_PINS: assert property (CFG_DONE && sf inside {[3'h4:3'h6]}
      |-> oe[3:2] == 2'h0) else $error("upper pins driven in rmii");
   AST_MII_DRIVE: assert property (s_settled ##0 sf <= 3'h3
      |-> oe == 4'hf && PORT0_OUT_DATA_VALID_OE)
      else $error("mii pins not driven");
   AST_ISOLATE: assert property (CFG_DONE && iso && $past(iso)
      && sf inside {[3'h1:3'h6]} |-> oe == 4'h0 && !PORT0_OUT_DATA_VALID_OE)
      else $error("pins driven while isolated");
   AST_RSVD_OFF: assert property (CFG_DONE && sf == 3'h7 |-> oe == 4'h0
      && !PORT0_OUT_DATA_VALID_OE && !PORT0_OUT_REF_CLOCK_OE)
      else $error("reserved code drives pins");
   AST_REF_PERIOD: assert property (CFG_CLK_OUT ##0 s_tick |->
      s_high_half) else $error("reference clock half period wrong");
   AST_PIN_STEP: assert property (CFG_DONE && CFG_CLK_OUT
      && ($changed(PORT0_OUT_DATA_NIBBLE_O)
      || $changed(PORT0_OUT_DATA_VALID_O)) |-> s_tick)
      else $error("data pins moved off the reference tick");
   AST_IDLE_ZERO: assert property (CFG_DONE && !PORT0_OUT_DATA_VALID_O
      |-> PORT0_OUT_DATA_NIBBLE_O == 4'h0)
      else $error("data pins not quiet while idle");
endmodule : pmx_props

bind pmx_top pmx_props i_props (
   .CLK(CLK), .RST(RST), .TX_READY(TX_READY),
   .ISOLATE_OUTPUTS_BIT(ISOLATE_OUTPUTS_BIT),
   .PORT0_OUT_REF_CLOCK_O(PORT0_OUT_REF_CLOCK_O),
   .PORT0_OUT_REF_CLOCK_OE(PORT0_OUT_REF_CLOCK_OE),
   .PORT0_OUT_DATA_NIBBLE_I(PORT0_OUT_DATA_NIBBLE_I),
   .PORT0_OUT_DATA_NIBBLE_O(PORT0_OUT_DATA_NIBBLE_O),
   .PORT0_OUT_DATA_NIBBLE_OE(PORT0_OUT_DATA_NIBBLE_OE),
   .PORT0_OUT_DATA_VALID_O(PORT0_OUT_DATA_VALID_O),
   .PORT0_OUT_DATA_VALID_OE(PORT0_OUT_DATA_VALID_OE),
   .PORT0_CFG_STRAP_FIELD(PORT0_CFG_STRAP_FIELD),
   .CFG_SPEED_200(CFG_SPEED_200), .CFG_CLK_16MA(CFG_CLK_16MA),
   .CFG_CLK_OUT(CFG_CLK_OUT), .CFG_DONE(CFG_DONE));

// >>> bench/pmx_far_end.sv
// far side model: external mac or phy on the port 0 output pins
`timescale 1ns/1ns

module pmx_far_end (
   input wire logic drv_clk,
   input wire logic rmii,
   input wire logic ref_pin,
   input wire logic [3:0] data,
   input wire logic valid,
   input wire logic valid_oe,
   output logic ref_drv
);
   logic [3:0] rx_q[$]; // nibbles seen on the pins
   logic [1:0] lo_r; // first dibit of an rmii nibble
   logic ph_r = 1'b0; // high while the low dibit is held
   // own reference clock, still when the device owns the pin
   initial begin
      ref_drv = 1'b0;
      #37;
      forever begin
         #80;
         ref_drv = drv_clk ? ~ref_drv : 1'b0;
      end
   end
   // sample mid period; data stands a whole reference period
   always @(negedge ref_pin) begin
      if (!(valid && valid_oe)) begin
         ph_r = 1'b0;
      end else if (!rmii) begin
         rx_q.push_back(data);
      end else if (!ph_r) begin
         lo_r = data[1:0];
         ph_r = 1'b1;
      end else begin
         rx_q.push_back({data[1:0], lo_r});
         ph_r = 1'b0;
      end
   end
endmodule : pmx_far_end

// >>> bench/pmx_top_tb_top.sv
// self-checking bench for the port 0 output pin mux
`timescale 1ns/1ns
`include "pmx_consts.svh"

module pmx_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] tx_data = 4'h0;
   logic tx_valid = 1'b0;
   logic iso = 1'b0;
   logic [2:0] strap = 3'h0; // level on data pins during reset
   logic tx_ready, ref_o, ref_oe, dv_o, dv_oe, spd, c16, cout, done;
   logic [3:0] nib_o, nib_oe;
   logic [2:0] sf;
   logic ref_drv;
   int n_errors = 0;
   int num_checks = 0;
   // pin levels: device drive, far side clock, pull-down on the clock,
   // pull-ups on the strap pins once released
   wire ref_pin = ref_oe ? ref_o : ref_drv;
   wire [2:0] nib_i = rst ? strap : (nib_o[2:0] & nib_oe[2:0]) | ~nib_oe[2:0];

   always #5 clk = ~clk;

   pmx_top i_dut (.CLK(clk), .RST(rst), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .ISOLATE_OUTPUTS_BIT(iso),
      .PORT0_OUT_REF_CLOCK_I(ref_pin), .PORT0_OUT_REF_CLOCK_O(ref_o),
      .PORT0_OUT_REF_CLOCK_OE(ref_oe), .PORT0_OUT_DATA_NIBBLE_I(nib_i),
      .PORT0_OUT_DATA_NIBBLE_O(nib_o), .PORT0_OUT_DATA_NIBBLE_OE(nib_oe),
      .PORT0_OUT_DATA_VALID_O(dv_o), .PORT0_OUT_DATA_VALID_OE(dv_oe),
      .PORT0_CFG_STRAP_FIELD(sf), .CFG_SPEED_200(spd),
      .CFG_CLK_16MA(c16), .CFG_CLK_OUT(cout), .CFG_DONE(done));

   pmx_far_end i_far (.drv_clk(!cout && done), .rmii(sf[2]),
      .ref_pin(ref_pin), .data(nib_o), .valid(dv_o), .valid_oe(dv_oe),
      .ref_drv(ref_drv));

   // expected data pin enables per strap code
   function automatic logic [3:0] exp_oe(input logic [2:0] m);
      return (m == 3'h7) ? 4'h0 : (m >= 3'h4) ? 4'h3 : 4'hf;
   endfunction : exp_oe

   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk

   // offer one nibble, holding it until ready was seen at an edge
   task automatic push(input logic [3:0] d);
      logic ok;
      int n;
      tx_data = d;
      tx_valid = 1'b1;
      ok = 1'b0;
      n = 0;
      while (!ok && n < 300) begin
         ok = (tx_ready === 1'b1);
         @(posedge clk);
         #1;
         n++;
      end
      if (!ok) chk("tx_ready wait", 8'h01, 8'h00);
   endtask : push

   task automatic run_mode(input logic [2:0] m);
      logic [3:0] exp_q[$];
      logic [3:0] d;
      int i;
      rst = 1'b1;
      strap = m;
      iso = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk("enables in reset", 8'h00, {3'h0, ref_oe, nib_oe});
      chk("ready in reset", 8'h00, {7'h0, tx_ready});
      rst = 1'b0;
      i_far.rx_q.delete();
      repeat (3) @(posedge clk);
      #1;
      chk("strap", {5'h0, m}, {5'h0, sf});
      chk("decode", {5'h0, m == 3'h2 || m == 3'h3, m == 3'h3 || m == 3'h5,
         m inside {[3'h1:3'h5]}}, {5'h0, spd, c16, cout});
      chk("enables", {2'h0, m inside {[3'h1:3'h5]}, m != 3'h7, exp_oe(m)},
         {2'h0, ref_oe, dv_oe, nib_oe});
      if (m == 3'h7) begin
         for (i = 0; i < 4; i++) push(4'($urandom));
         tx_valid = 1'b1;
         repeat (4) @(posedge clk);
         #1;
         tx_valid = 1'b0;
         chk("ready when full", 8'h00, {7'h0, tx_ready});
         chk("rx count", 8'h00, 8'(i_far.rx_q.size()));
         return;
      end
      // corner nibbles first, then random ones back to back
      for (i = 0; i < 10; i++) begin
         d = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
         exp_q.push_back(d);
         push(d);
      end
      tx_valid = 1'b0;
      i = 0;
      while (i_far.rx_q.size() < 10 && i < 2000) begin
         @(posedge clk);
         i++;
      end
      #1;
      chk("rx count", 8'h0a, 8'(i_far.rx_q.size()));
      foreach (exp_q[k]) begin
         if (k < i_far.rx_q.size())
            chk("rx nibble", {4'h0, exp_q[k]}, {4'h0, i_far.rx_q[k]});
      end
      iso = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("isolated", (m == 3'h0) ? 8'h1f : 8'h00,
         {3'h0, dv_oe, nib_oe});
      iso = 1'b0;
   endtask : run_mode

   task automatic wrap_up;
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // watchdog: about seventeen times the expected run length
   initial begin
      #300000;
      n_errors++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h8669ae48));
      for (int m = 0; m < 8; m++) run_mode(3'(m));
      wrap_up();
   end
endmodule : pmx_top_tb_top
